// ### core/osw_pkg.sv
package osw_pkg;

	// Channel count and the two channels that take direct PWM inputs.
	localparam int        CH_NUM    = 8;
	localparam int        PWM_IDX_A = 4;
	localparam int        PWM_IDX_B = 5;

	// Reset values of the command latch and fault status register.
	localparam logic [7:0] CMD_RST   = 8'h00;
	localparam logic [7:0] FAULT_RST = 8'h00;

	// Off-state open-load filter time, least figure, and clock period.
	localparam int        OL_FILTER_NS  = 100000;
	localparam int        REF_CLK_NS    = 25;
	localparam int        OL_FILTER_CYC =
		(OL_FILTER_NS + REF_CLK_NS - 1) / REF_CLK_NS;
	localparam int        OL_CNT_W      = $clog2(OL_FILTER_CYC + 1);

	// Positions in the synchronised control vector.
	localparam int        CTL_CS  = 0;
	localparam int        CTL_PA  = 1;
	localparam int        CTL_PB  = 2;
	localparam int        CTL_EN  = 3;
	localparam int        CTL_LOW = 4;
	localparam int        CTL_OV  = 5;
	localparam int        CTL_W   = 6;

endpackage

// ### core/osw_switch_ctrl.sv
`timescale 1ns/1ps

module osw_switch_ctrl
	import osw_pkg::*;
#(
	parameter int CH_N = CH_NUM
) (
	input  wire logic            ref_clk,
	input  wire logic            rst,
	input  wire logic            sclk,
	input  wire logic            cs_n,
	input  wire logic            serial_cmd_in,
	output logic                 serial_out,
	output logic                 serial_out_oe_n,
	input  wire logic            direct_pwm_in_a,
	input  wire logic            direct_pwm_in_b,
	input  wire logic            enable,
	input  wire logic            logic_supply_low,
	input  wire logic            power_supply_ov,
	input  wire logic [CH_N-1:0] over_temp,
	input  wire logic [CH_N-1:0] short_det,
	input  wire logic [CH_N-1:0] open_det,
	output logic      [CH_N-1:0] channel_drive
);

	// The PWM channel positions must exist in the word.
	if (CH_N != CH_NUM) begin : g_chk
		$error("CH_N must equal the fixed channel count");
	end

	logic [CTL_W-1:0]    ctl_s1_reg;
	logic [CTL_W-1:0]    ctl_s2_reg;
	logic [3*CH_N-1:0]   flt_s1_reg;
	logic [3*CH_N-1:0]   flt_s2_reg;
	logic                cs_d_reg;
	logic [CH_N-1:0]     shift_reg;
	logic                started_reg;
	logic                do_reg;
	logic [CH_N-1:0]     cmd_reg;
	logic [CH_N-1:0]     snap_reg;
	logic [CH_N-1:0]     fault_reg;
	logic [CH_N-1:0]     fault_next;
	logic [CH_N-1:0]     drive_reg;
	logic [CH_N-1:0]     cmd_eff;
	logic [CH_N-1:0]     ot_s;
	logic [CH_N-1:0]     sh_s;
	logic [CH_N-1:0]     op_s;
	logic [CH_N-1:0]     flt_now;
	logic [OL_CNT_W-1:0] ol_cnt_reg;
	logic                ol_ok;
	logic                cs_s;
	logic                cs_rise;
	logic                cs_fall;
	logic                en_s;
	logic                low_s;
	logic                ov_s;

	// Two-flop synchronisers for every pin read by the ref_clk logic except rst.
	always_ff @(posedge ref_clk) begin
		ctl_s1_reg <= {power_supply_ov, logic_supply_low, enable,
			direct_pwm_in_b, direct_pwm_in_a, cs_n};
		ctl_s2_reg <= ctl_s1_reg;
		flt_s1_reg <= {open_det, short_det, over_temp};
		flt_s2_reg <= flt_s1_reg;
	end

	assign cs_s  = ctl_s2_reg[CTL_CS];
	assign en_s  = ctl_s2_reg[CTL_EN];
	assign low_s = ctl_s2_reg[CTL_LOW];
	assign ov_s  = ctl_s2_reg[CTL_OV];
	assign ot_s  = flt_s2_reg[CH_N-1:0];
	assign sh_s  = flt_s2_reg[2*CH_N-1:CH_N];
	assign op_s  = flt_s2_reg[3*CH_N-1:2*CH_N];

	// Edge detection of the synchronised chip select.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cs_d_reg <= 1'b1;
		end else begin
			cs_d_reg <= cs_s;
		end
	end

	assign cs_rise = cs_s & ~cs_d_reg;
	assign cs_fall = ~cs_s & cs_d_reg;

	// Link side: the frame signal clears the state, so idle clocks
	// are ignored and nothing relies on an edge outside a frame.
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			started_reg <= 1'b0;
		end else begin
			started_reg <= 1'b1;
		end
	end

	// Shift register: the first falling edge pulls the loaded status
	// word forward, later ones shift. Held while deselected.
	always_ff @(negedge sclk) begin
		if (!cs_n) begin
			if (!started_reg) begin
				shift_reg <= {snap_reg[CH_N-2:0], serial_cmd_in};
			end else begin
				shift_reg <= {shift_reg[CH_N-2:0], serial_cmd_in};
			end
		end
	end

	// Serial output: first rising edge shows channel eight status.
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			do_reg <= 1'b0;
		end else if (!started_reg) begin
			do_reg <= snap_reg[CH_N-1];
		end else begin
			do_reg <= shift_reg[CH_N-1];
		end
	end

	assign serial_out      = do_reg;
	assign serial_out_oe_n = cs_n;

	// Command latch; shift_reg is quiet once chip select is high.
	always_ff @(posedge ref_clk) begin
		if (rst || low_s) begin
			cmd_reg <= CMD_RST;
		end else if (cs_rise) begin
			cmd_reg <= shift_reg;
		end
	end

	// Status snapshot at chip-select fall, held for the frame.
	always_ff @(posedge ref_clk) begin
		if (rst || low_s) begin
			snap_reg <= FAULT_RST;
		end else if (cs_fall) begin
			snap_reg <= fault_reg;
		end
	end

	// Open-load filter timer restarted by each chip-select rise.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ol_cnt_reg <= OL_CNT_W'(OL_FILTER_CYC);
		end else if (cs_rise) begin
			ol_cnt_reg <= OL_CNT_W'(OL_FILTER_CYC);
		end else if (!ol_ok) begin
			ol_cnt_reg <= ol_cnt_reg - 1'b1;
		end
	end

	assign ol_ok = (ol_cnt_reg == '0);

	// Present faults: on-state short or heat, off-state open load.
	always_comb begin
		flt_now = ((sh_s | ot_s) & cmd_eff)
			| (op_s & ~cmd_eff & {CH_N{ol_ok}});
		if (!en_s) begin
			flt_now = '0;
		end
	end

	// Fault bits latch; a capture while enabled clears those no longer present,
	// and a new fault in that cycle wins.
	always_comb begin
		fault_next = fault_reg | flt_now;
		if (cs_fall) begin
			fault_next = flt_now;
		end
		if (!en_s) begin
			fault_next = fault_reg;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || low_s) begin
			fault_reg <= FAULT_RST;
		end else begin
			fault_reg <= fault_next;
		end
	end

	// Effective command with the PWM inputs ORed into two channels.
	always_comb begin
		cmd_eff            = cmd_reg;
		cmd_eff[PWM_IDX_A] = cmd_reg[PWM_IDX_A] | ctl_s2_reg[CTL_PA];
		cmd_eff[PWM_IDX_B] = cmd_reg[PWM_IDX_B] | ctl_s2_reg[CTL_PB];
	end

	// Driver register; off under enable low or overvoltage, and back
	// to the kept command once the condition goes away.
	always_ff @(posedge ref_clk) begin
		if (rst || low_s) begin
			drive_reg <= '0;
		end else if (!en_s || ov_s) begin
			drive_reg <= '0;
		end else begin
			drive_reg <= cmd_eff & ~ot_s;
		end
	end

	// Heat shutdown gates the pin at once, without waiting a clock.
	assign channel_drive = drive_reg & ~over_temp;

	// Checks.
	sequence s_rise;
		cs_rise && !low_s;
	endsequence

	sequence s_filter_hold;
		!ol_ok [*8];
	endsequence

	property p_latch;
		@(posedge ref_clk) disable iff (rst)
		s_rise |=> cmd_reg == $past(shift_reg);
	endproperty
	a_latch: assert property (p_latch)
		else $error("command not latched at select rise");

	property p_snap;
		@(posedge ref_clk) disable iff (rst)
		(cs_fall && !low_s) |=> snap_reg == $past(fault_reg);
	endproperty
	a_snap: assert property (p_snap)
		else $error("status not captured at select fall");

	property p_hiz;
		@(posedge ref_clk) disable iff (rst)
		cs_n |-> serial_out_oe_n && !serial_out;
	endproperty
	a_hiz: assert property (p_hiz)
		else $error("serial output driven while deselected");

	property p_first;
		@(negedge sclk) disable iff (cs_n)
		!started_reg |-> serial_out == snap_reg[CH_N-1];
	endproperty
	a_first: assert property (p_first)
		else $error("first bit is not channel eight status");

	property p_shift;
		@(negedge sclk) disable iff (cs_n)
		started_reg |=> shift_reg[CH_N-1:1] == $past(shift_reg[CH_N-2:0]);
	endproperty
	a_shift: assert property (p_shift)
		else $error("shift register did not shift");

	property p_drive;
		@(posedge ref_clk) disable iff (rst)
		(en_s && !ov_s && !low_s) |=> drive_reg == $past(cmd_eff & ~ot_s);
	endproperty
	a_drive: assert property (p_drive)
		else $error("drivers do not follow command");

	property p_off;
		@(posedge ref_clk) disable iff (rst)
		(!en_s || ov_s || low_s) |=> drive_reg == '0;
	endproperty
	a_off: assert property (p_off)
		else $error("drivers not off when disabled");

	property p_heat;
		@(posedge ref_clk) disable iff (rst)
		(ot_s != '0) |=> (drive_reg & $past(ot_s)) == '0;
	endproperty
	a_heat: assert property (p_heat)
		else $error("hot channel still driven");

	property p_filter;
		@(posedge ref_clk) disable iff (rst)
		cs_rise |=> s_filter_hold;
	endproperty
	a_filter: assert property (p_filter)
		else $error("open-load filter expired early");

	property p_keep;
		@(posedge ref_clk) disable iff (rst)
		(!cs_fall && !low_s) |=>
			(fault_reg & $past(fault_reg)) == $past(fault_reg);
	endproperty
	a_keep: assert property (p_keep)
		else $error("latched fault lost outside capture");

	property p_uv;
		@(posedge ref_clk) disable iff (rst)
		low_s |=> fault_reg == '0 && cmd_reg == '0;
	endproperty
	a_uv: assert property (p_uv)
		else $error("undervoltage did not clear state");

endmodule

// ### testbench/osw_host.sv
`timescale 1ns/1ps

// Serial master standing in for the host controller at the far side.
module osw_host (
	output logic      sclk,
	output logic      cs_n,
	output logic      serial_cmd_in,
	input  wire logic serial_out,
	input  wire logic serial_out_oe_n
);
	// Idle state: clock parked low, device deselected.
	initial begin
		sclk = 1'b0;
		serial_cmd_in = 1'b0;
		// A select rise after time zero clears started_reg and do_reg.
		#1 cs_n = 1'b1;
	end

	// One frame of n bits, most significant bit first, returning what came back.
	task automatic xfer(input int n, input logic [15:0] tx,
		output logic [15:0] rx);
		int i;
		rx = 16'h0000;
		cs_n = 1'b0;
		#200;
		for (i = n - 1; i >= 0; i--) begin
			#15 sclk = 1'b1;
			serial_cmd_in = tx[i];
			#10 rx = {rx[14:0], serial_out_oe_n ? 1'bx : serial_out};
			#5 sclk = 1'b0;
		end
		#50 cs_n = 1'b1;
		serial_cmd_in = ~serial_cmd_in; // A released line keeps no value.
	endtask
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps

// Self-checking bench for the octal switch control block.
module testbench;
	import osw_pkg::*;
	logic        ref_clk, rst, sclk, cs_n, sdi, sdo, sdo_oe_n;
	logic        pwm_a, pwm_b, en, lsl, ov;
	logic [7:0]  ot, sh, op, drv;
	logic [15:0] rx;
	int          fails, samples_checked;

	osw_switch_ctrl osw_switch_ctrl_i (.ref_clk(ref_clk), .rst(rst),
		.sclk(sclk), .cs_n(cs_n), .serial_cmd_in(sdi), .serial_out(sdo),
		.serial_out_oe_n(sdo_oe_n), .direct_pwm_in_a(pwm_a),
		.direct_pwm_in_b(pwm_b), .enable(en), .logic_supply_low(lsl),
		.power_supply_ov(ov), .over_temp(ot), .short_det(sh),
		.open_det(op), .channel_drive(drv));
	osw_host osw_host_i (.sclk(sclk), .cs_n(cs_n), .serial_cmd_in(sdi),
		.serial_out(sdo), .serial_out_oe_n(sdo_oe_n));

	// System clock, 25 ns period.
	initial ref_clk = 1'b0;
	always #12.5 ref_clk = ~ref_clk;

	// Compares a seen value with the expected one and counts both outcomes.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic conclude();
		if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Waits a bounded time for the drivers to settle on a value.
	task automatic expect_drive(input logic [7:0] exp);
		int k;
		for (k = 0; k < 40 && drv !== exp; k++) @(negedge ref_clk);
		check(drv, exp);
		if (drv !== exp) conclude();
	endtask

	// One 8-bit frame with the status word that should come back.
	task automatic frame(input logic [7:0] tx, input logic [7:0] exp);
		osw_host_i.xfer(8, {8'h00, tx}, rx);
		check(rx[7:0], exp);
		repeat (6) @(negedge ref_clk);
	endtask

	// Spacing between frames so fault status is settled.
	task automatic gap();
		repeat (12100) @(negedge ref_clk);
	endtask

	// Cuts a hang short.
	initial begin
		#2400000;
		fails++;
		conclude();
	end

	// Main sequence.
	initial begin
		{rst, en} = 2'b11;
		{pwm_a, pwm_b, lsl, ov} = 4'h0;
		{ot, sh, op} = 24'h000000;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		check(drv, 8'h00);
		check({7'h00, sdo_oe_n}, 8'h01);
		repeat (4) @(negedge ref_clk);
		frame(8'h81, 8'h00);
		expect_drive(8'h81);
		sh = 8'h80; // Short on channel eight while it is on.
		repeat (20) @(negedge ref_clk);
		sh = 8'h00;
		gap();
		frame(8'h80, 8'h80);
		op = 8'h01; // Open load on channel one while it is off.
		frame(8'h80, 8'h00);
		gap();
		op = 8'h00;
		repeat (10) @(negedge ref_clk);
		frame(8'h80, 8'h01);
		gap();
		frame(8'h80, 8'h00);
		osw_host_i.xfer(16, 16'h5a03, rx);
		check(rx[7:0], 8'h5a);
		expect_drive(8'h03);
		pwm_a = 1'b1;
		expect_drive(8'h13);
		pwm_a = 1'b0;
		pwm_b = 1'b1;
		expect_drive(8'h23);
		ot = 8'h02;
		#1 check(drv, 8'h21);
		repeat (6) @(negedge ref_clk);
		check(drv, 8'h21);
		ot = 8'h00;
		expect_drive(8'h23);
		en = 1'b0;
		expect_drive(8'h00);
		en = 1'b1;
		expect_drive(8'h23);
		ov = 1'b1;
		expect_drive(8'h00);
		ov = 1'b0;
		expect_drive(8'h23);
		lsl = 1'b1;
		expect_drive(8'h00);
		lsl = 1'b0;
		expect_drive(8'h20);
		frame(8'h00, 8'h00);
		conclude();
	end
endmodule
